// ==== core/accel_control_interface.sv ====
// Control register, scalar argument queues and stream channels around a hardware accelerator
`timescale 1ns/1ps
module accel_control_interface
#(
	parameter accel_ctrl_pkg::protocol_t PROTOCOL    = accel_ctrl_pkg::PROTO_NATIVE,
	parameter int                        NUM_IN_STR  = 8,
	parameter int                        NUM_OUT_STR = 8,
	parameter int                        ARG_W       = 32
)
(
	input  wire logic                                       clk,
	input  wire logic                                       rst,
	input  wire accel_ctrl_pkg::reg_req_t                   reg_req,
	output logic        [accel_ctrl_pkg::DATA_W-1:0]        reg_rdata,
	output logic                                            reg_rvalid,
	output logic                                            launch_request,
	input  wire logic                                       acc_done,
	input  wire logic                                       acc_idle,
	input  wire logic                                       acc_ready,
	output logic        [7:0][accel_ctrl_pkg::DATA_W-1:0]   acc_in_scalar,
	input  wire logic   [7:0][accel_ctrl_pkg::DATA_W-1:0]   acc_out_scalar,
	output logic        [7:0][accel_ctrl_pkg::DATA_W-1:0]   acc_io_scalar,
	input  wire logic   [7:0][accel_ctrl_pkg::DATA_W-1:0]   acc_io_result,
	input  wire logic   [7:0]                               acc_io_we,
	input  wire accel_ctrl_pkg::stream_t [NUM_IN_STR-1:0]   net_in,
	output logic        [NUM_IN_STR-1:0]                    net_in_ready,
	output accel_ctrl_pkg::stream_t [NUM_IN_STR-1:0]        acc_in,
	input  wire logic   [NUM_IN_STR-1:0]                    acc_in_ready,
	input  wire accel_ctrl_pkg::stream_t [NUM_OUT_STR-1:0]  acc_out,
	output logic        [NUM_OUT_STR-1:0]                   acc_out_ready,
	output accel_ctrl_pkg::stream_t [NUM_OUT_STR-1:0]       net_out,
	input  wire logic   [NUM_OUT_STR-1:0]                   net_out_ready
);
	import accel_ctrl_pkg::*;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	localparam logic HAS_REGS   = (PROTOCOL != PROTO_STREAM);
	localparam logic HAS_SCALAR = (PROTOCOL == PROTO_ADAPTER);

	logic        wr_en;
	logic        rd_en;
	logic        ctrl_hit;
	logic [2:0]  idx;
	logic        handshake;
	logic        any_in_valid;
	logic        finished_q;
	logic        quiescent_q;
	logic        accept_q;
	logic        autorerun_q;
	logic [15:0] pkt_len_q;
	logic [7:0][DATA_W-1:0] in_pend_q;
	logic [7:0][DATA_W-1:0] io_pend_q;
	logic [7:0][DATA_W-1:0] out_q;
	logic [7:0][DATA_W-1:0] io_res_q;

	assign wr_en     = HAS_REGS && reg_req.en && reg_req.wr;
	assign rd_en     = HAS_REGS && reg_req.en && !reg_req.wr;
	assign ctrl_hit  = (reg_req.addr == OFF_CONTROL);
	assign idx       = reg_req.addr[4:2];
	assign handshake = launch_request && acc_ready;

	// Stream-only start needs to see any channel offering a beat
	always_comb
	begin
		any_in_valid = 1'b0;
		for (int i = 0; i < NUM_IN_STR; i++)
			any_in_valid = any_in_valid | net_in[i].tvalid;
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Launch: set by software, by auto-rerun or by stream arrival; set wins over handshake clear
	always_ff @(posedge clk)
	begin
		if (rst)
			launch_request <= 1'b0;
		else if (wr_en && ctrl_hit && reg_req.wdata[BIT_LAUNCH])
			launch_request <= 1'b1;
		else if (autorerun_q && acc_done && HAS_REGS)
			launch_request <= 1'b1;
		else if (!HAS_REGS && any_in_valid && acc_idle && !launch_request)
			launch_request <= 1'b1;
		else if (handshake)
			launch_request <= 1'b0;
	end

	// Finished: sticky on completion, cleared by reading the control word; completion wins
	always_ff @(posedge clk)
	begin
		if (rst)
			finished_q <= 1'b0;
		else if (acc_done)
			finished_q <= 1'b1;
		else if (rd_en && ctrl_hit)
			finished_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			quiescent_q <= 1'b1;
			accept_q    <= 1'b0;
		end
		else
		begin
			quiescent_q <= acc_idle;
			accept_q    <= acc_ready;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			autorerun_q <= 1'b0;
		else if (wr_en && ctrl_hit)
			autorerun_q <= reg_req.wdata[BIT_AUTORERUN];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pkt_len_q <= PKT_LEN_RESET;
		else if (wr_en && reg_req.addr == OFF_PKT_LEN && reg_req.wdata[15:0] != 16'h0000)
			pkt_len_q <= reg_req.wdata[15:0];
	end

	// ------------------------------------------------------------
	// Scalar argument queues
	// ------------------------------------------------------------
	// Software stages the next call's inputs while the current call runs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			in_pend_q <= '0;
			io_pend_q <= '0;
		end
		else if (wr_en && HAS_SCALAR)
		begin
			if (reg_req.addr[7:5] == OFF_IN_BASE[7:5])
				in_pend_q[idx] <= reg_req.wdata;
			if (reg_req.addr[7:5] == OFF_IO_BASE[7:5])
				io_pend_q[idx] <= reg_req.wdata;
		end
	end

	// Staged inputs move to the accelerator at the start handshake
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc_in_scalar <= '0;
			acc_io_scalar <= '0;
		end
		else if (handshake && HAS_SCALAR)
		begin
			acc_in_scalar <= in_pend_q;
			acc_io_scalar <= io_pend_q;
		end
	end

	// Results, return value among them, captured on completion
	always_ff @(posedge clk)
	begin
		if (rst)
			out_q <= '0;
		else if (acc_done && HAS_SCALAR)
			out_q <= acc_out_scalar;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			io_res_q <= '0;
		else if (acc_done && HAS_SCALAR)
		begin
			for (int i = 0; i < NUM_SCALAR; i++)
				io_res_q[i] <= acc_io_we[i] ? acc_io_result[i] : io_pend_q[i];
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [DATA_W-1:0] rdata_d;

	always_comb
	begin
		rdata_d = '0;
		if (ctrl_hit)
		begin
			rdata_d[BIT_LAUNCH]    = launch_request;
			rdata_d[BIT_FINISHED]  = finished_q;
			rdata_d[BIT_QUIESCENT] = quiescent_q;
			rdata_d[BIT_ACCEPT]    = accept_q;
			rdata_d[BIT_AUTORERUN] = autorerun_q;
		end
		else if (reg_req.addr == OFF_PKT_LEN)
			rdata_d[15:0] = pkt_len_q;
		else if (HAS_SCALAR)
		begin
			unique case (reg_req.addr[7:5])
				OFF_IN_BASE[7:5]:  rdata_d = in_pend_q[idx];
				OFF_OUT_BASE[7:5]: rdata_d = out_q[idx];
				OFF_IO_BASE[7:5]:  rdata_d = io_res_q[idx];
				default:           rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= rd_en;
			reg_rdata  <= rd_en ? rdata_d : '0;
		end
	end

	// ------------------------------------------------------------
	// Inbound stream channels
	// ------------------------------------------------------------
	// One-deep buffer per channel; ready comes from a flop, so throughput is one beat in two
	for (genvar g = 0; g < NUM_IN_STR; g++)
	begin : g_in
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				acc_in[g]       <= '0;
				net_in_ready[g] <= 1'b0;
			end
			else if (acc_in[g].tvalid)
			begin
				net_in_ready[g] <= 1'b0;
				if (acc_in_ready[g])
				begin
					acc_in[g].tvalid <= 1'b0;
					net_in_ready[g]  <= 1'b1;
				end
			end
			else if (net_in_ready[g] && net_in[g].tvalid)
			begin
				acc_in[g]       <= net_in[g];
				net_in_ready[g] <= 1'b0;
			end
			else
				net_in_ready[g] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Outbound stream channels
	// ------------------------------------------------------------
	// Beats are counted per packet so the boundary marker is generated here
	for (genvar g = 0; g < NUM_OUT_STR; g++)
	begin : g_out
		logic [15:0] beat_q;
		logic        last_beat;

		assign last_beat = (beat_q == pkt_len_q - 16'h0001);

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				net_out[g]       <= '0;
				acc_out_ready[g] <= 1'b0;
				beat_q           <= '0;
			end
			else if (net_out[g].tvalid)
			begin
				acc_out_ready[g] <= 1'b0;
				if (net_out_ready[g])
				begin
					net_out[g].tvalid <= 1'b0;
					acc_out_ready[g]  <= 1'b1;
				end
			end
			else if (acc_out_ready[g] && acc_out[g].tvalid)
			begin
				net_out[g].tvalid <= 1'b1;
				net_out[g].tdata  <= acc_out[g].tdata;
				net_out[g].tkeep  <= {KEEP_W{1'b1}};
				net_out[g].tlast  <= last_beat;
				beat_q           <= last_beat ? 16'h0000 : beat_q + 16'h0001;
				acc_out_ready[g] <= 1'b0;
			end
			else
				acc_out_ready[g] <= 1'b1;
		end

		property p_out_keep;
			@(posedge clk) disable iff (rst)
			net_out[g].tvalid |-> net_out[g].tkeep == {KEEP_W{1'b1}};
		endproperty
		a_out_keep: assert property (p_out_keep) else $error("outbound keep not full");

		property p_out_hold;
			@(posedge clk) disable iff (rst)
			net_out[g].tvalid && !net_out_ready[g] |=> net_out[g].tvalid && $stable(net_out[g].tdata);
		endproperty
		a_out_hold: assert property (p_out_hold) else $error("outbound beat dropped under stall");
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_launch_write;
		wr_en && ctrl_hit && reg_req.wdata[BIT_LAUNCH];
	endsequence

	property p_launch_set;
		@(posedge clk) disable iff (rst)
		s_launch_write |=> launch_request;
	endproperty
	a_launch_set: assert property (p_launch_set) else $error("launch write not taken");
	property p_launch_clear;
		@(posedge clk) disable iff (rst)
		handshake && !(wr_en && ctrl_hit && reg_req.wdata[BIT_LAUNCH]) && !(autorerun_q && acc_done)
			&& !(!HAS_REGS && any_in_valid && acc_idle) |=> !launch_request;
	endproperty
	a_launch_clear: assert property (p_launch_clear) else $error("launch not cleared by handshake");
	property p_finished_read;
		@(posedge clk) disable iff (rst)
		rd_en && ctrl_hit && !acc_done |=> !finished_q;
	endproperty
	a_finished_read: assert property (p_finished_read) else $error("finished flag not cleared on read");
	property p_finished_set;
		@(posedge clk) disable iff (rst)
		acc_done |=> finished_q;
	endproperty
	a_finished_set: assert property (p_finished_set) else $error("completion lost");
	property p_ctrl_read;
		@(posedge clk) disable iff (rst)
		rd_en && ctrl_hit |=> reg_rvalid && reg_rdata[6:4] == 3'b000 && reg_rdata[DATA_W-1:8] == '0
			&& reg_rdata[BIT_AUTORERUN] == $past(autorerun_q);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control word read wrong");
	property p_rerun;
		@(posedge clk) disable iff (rst)
		autorerun_q && acc_done && HAS_REGS |=> launch_request;
	endproperty
	a_rerun: assert property (p_rerun) else $error("no relaunch after completion");
	property p_stream_only;
		@(posedge clk) disable iff (rst)
		!HAS_REGS |-> !reg_rvalid && !autorerun_q;
	endproperty
	a_stream_only: assert property (p_stream_only) else $error("registers active in stream-only mode");
	property p_scalar_queue;
		@(posedge clk) disable iff (rst)
		handshake && HAS_SCALAR |=> acc_in_scalar == $past(in_pend_q);
	endproperty
	a_scalar_queue: assert property (p_scalar_queue) else $error("staged scalars not delivered");
	property p_widths;
		@(posedge clk) disable iff (rst)
		(ARG_W == 8 || ARG_W == 16 || ARG_W == 32 || ARG_W == 64)
			&& NUM_IN_STR <= MAX_STREAMS && NUM_OUT_STR <= MAX_STREAMS;
	endproperty
	a_widths: assert property (p_widths) else $error("argument width or stream count out of range");

endmodule : accel_control_interface

// ==== core/accel_ctrl_pkg.sv ====
// Package: register map, field positions and carrier types for the accelerator control interface
// ------------------------------------------------------------
// ------------------------------------------------------------
package accel_ctrl_pkg;

	localparam int          DATA_W          = 32;
	localparam int          ADDR_W          = 8;
	localparam int          NUM_SCALAR      = 8;
	localparam int          MAX_STREAMS     = 8;
	localparam int          KEEP_W          = DATA_W / 8;

	localparam logic [7:0]  OFF_CONTROL     = 8'h00;
	localparam logic [7:0]  OFF_PKT_LEN     = 8'h04;
	localparam logic [7:0]  OFF_IN_BASE     = 8'h40;
	localparam logic [7:0]  OFF_OUT_BASE    = 8'h80;
	localparam logic [7:0]  OFF_IO_BASE     = 8'hc0;

	localparam int          BIT_LAUNCH      = 0;
	localparam int          BIT_FINISHED    = 1;
	localparam int          BIT_QUIESCENT   = 2;
	localparam int          BIT_ACCEPT      = 3;
	localparam int          BIT_AUTORERUN   = 7;

	localparam logic [15:0] PKT_LEN_RESET   = 16'h0001;
	localparam logic [31:0] SCALAR_RESET    = 32'h0000_0000;

	typedef enum logic [1:0] {
		PROTO_STREAM  = 2'b00,
		PROTO_ADAPTER = 2'b01,
		PROTO_NATIVE  = 2'b10
	} protocol_t;

	typedef struct packed {
		logic              en;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic              tvalid;
		logic [DATA_W-1:0] tdata;
		logic [KEEP_W-1:0] tkeep;
		logic              tlast;
	} stream_t;

endpackage : accel_ctrl_pkg

// ==== test/accel_model.sv ====
// Behavioural accelerator that answers the control handshake and loops streams back
`timescale 1ns/1ps
module accel_model
	import accel_ctrl_pkg::*;
#(
	parameter int LAT = 5,
	parameter int N   = 2
)
(
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire logic                               launch_request,
	output logic                                    acc_done,
	output logic                                    acc_idle,
	output logic                                    acc_ready,
	input  wire logic [7:0][accel_ctrl_pkg::DATA_W-1:0] acc_in_scalar,
	output logic      [7:0][accel_ctrl_pkg::DATA_W-1:0] acc_out_scalar,
	input  wire logic [7:0][accel_ctrl_pkg::DATA_W-1:0] acc_io_scalar,
	output logic      [7:0][accel_ctrl_pkg::DATA_W-1:0] acc_io_result,
	output logic      [7:0]                         acc_io_we,
	input  wire accel_ctrl_pkg::stream_t [N-1:0]    acc_in,
	output logic      [N-1:0]                       acc_in_ready,
	output accel_ctrl_pkg::stream_t [N-1:0]         acc_out,
	input  wire logic [N-1:0]                       acc_out_ready
);
	logic       busy_q;
	logic [7:0] cnt_q;

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	// Start is taken only while ready is shown, so launch and ready pair up
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busy_q   <= 1'b0;
			cnt_q    <= 8'h00;
			acc_done <= 1'b0;
		end
		else
		begin
			acc_done <= 1'b0;
			if (!busy_q && launch_request)
			begin
				busy_q <= 1'b1;
				cnt_q  <= 8'(LAT);
			end
			else if (busy_q)
			begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01)
				begin
					busy_q   <= 1'b0;
					acc_done <= 1'b1;
				end
			end
		end
	end

	assign acc_ready = !busy_q;
	assign acc_idle  = !busy_q;
	assign acc_io_we = 8'h0f;

	// ------------------------------------------------------------
	// Results and stream loopback
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			acc_out_scalar[i] = ~acc_in_scalar[i];
			acc_io_result[i]  = acc_io_scalar[i] + 32'h1;
		end
		for (int j = 0; j < N; j++)
		begin
			acc_out[j].tvalid = acc_in[j].tvalid;
			acc_out[j].tdata  = ~acc_in[j].tdata;
			acc_out[j].tkeep  = '1;
			acc_out[j].tlast  = acc_in[j].tlast;
		end
	end

	// Input pops exactly when the output beat is taken
	assign acc_in_ready = acc_out_ready;

endmodule : accel_model

// ==== test/test_accelerator_control_interface.sv ====
// Self-checking testbench for the accelerator control interface
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("Error %s expected %h seen %h", nm, exp, got); \
		end \
	end

module test_accelerator_control_interface;
	import accel_ctrl_pkg::*;
	localparam int N = 2;

	logic                    clk = 1'b0;
	logic                    rst;
	reg_req_t                reg_req;
	logic [DATA_W-1:0]       reg_rdata;
	logic                    reg_rvalid;
	logic                    launch_request;
	logic                    acc_done;
	logic                    acc_idle;
	logic                    acc_ready;
	logic [7:0][DATA_W-1:0]  acc_in_scalar;
	logic [7:0][DATA_W-1:0]  acc_out_scalar;
	logic [7:0][DATA_W-1:0]  acc_io_scalar;
	logic [7:0][DATA_W-1:0]  acc_io_result;
	logic [7:0]              acc_io_we;
	stream_t [N-1:0]         net_in;
	logic [N-1:0]            net_in_ready;
	stream_t [N-1:0]         acc_in;
	logic [N-1:0]            acc_in_ready;
	stream_t [N-1:0]         acc_out;
	logic [N-1:0]            acc_out_ready;
	stream_t [N-1:0]         net_out;
	logic [N-1:0]            net_out_ready;
	int                      failures = 0;
	int                      check_count = 0;
	int                      cycles = 0;
	logic [31:0]             vin [8];
	logic [31:0]             vio [8];
	logic [31:0]             exp_q [$];
	logic [31:0]             rnd;

	always #50 clk = ~clk;

	accel_control_interface #(.PROTOCOL(PROTO_ADAPTER), .NUM_IN_STR(N), .NUM_OUT_STR(N)) accel_control_interface_i (
		.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.launch_request(launch_request), .acc_done(acc_done), .acc_idle(acc_idle), .acc_ready(acc_ready),
		.acc_in_scalar(acc_in_scalar), .acc_out_scalar(acc_out_scalar), .acc_io_scalar(acc_io_scalar),
		.acc_io_result(acc_io_result), .acc_io_we(acc_io_we), .net_in(net_in), .net_in_ready(net_in_ready),
		.acc_in(acc_in), .acc_in_ready(acc_in_ready), .acc_out(acc_out), .acc_out_ready(acc_out_ready),
		.net_out(net_out), .net_out_ready(net_out_ready));

	accel_model #(.LAT(5), .N(N)) accel_model_i (
		.clk(clk), .rst(rst), .launch_request(launch_request), .acc_done(acc_done), .acc_idle(acc_idle),
		.acc_ready(acc_ready), .acc_in_scalar(acc_in_scalar), .acc_out_scalar(acc_out_scalar),
		.acc_io_scalar(acc_io_scalar), .acc_io_result(acc_io_result), .acc_io_we(acc_io_we),
		.acc_in(acc_in), .acc_in_ready(acc_in_ready), .acc_out(acc_out), .acc_out_ready(acc_out_ready));

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_req <= '{en: 1'b1, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		reg_req.en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		reg_req <= '{en: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
		@(posedge clk);
		reg_req.en <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK(nm, e, reg_rdata)
	endtask : rd

	// Ends at the edge where the completion pulse is sampled
	task automatic wait_done();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (acc_done !== 1'b1 && n < 100);
		if (n >= 100)
			failures++;
	endtask : wait_done

	// Inout results: the model writes back the low four, the rest keep their staged value
	function automatic logic [31:0] io_expect(input int i, input logic [31:0] v);
		return (i < 4) ? v + 32'h1 : v;
	endfunction : io_expect

	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// Stream traffic
	// ------------------------------------------------------------
	task automatic send();
		@(posedge clk);
		for (int k = 0; k < 6; k++)
		begin
			rnd = $urandom;
			exp_q.push_back(~rnd);
			net_in[0] <= '{tvalid: 1'b1, tdata: rnd, tkeep: 4'hf, tlast: 1'b0};
			do
				@(posedge clk);
			while (net_in_ready[0] !== 1'b1);
		end
		net_in[0].tvalid <= 1'b0;
	endtask : send

	task automatic recv();
		int k;
		int n;
		logic [31:0] ev;
		k = 0;
		n = 0;
		while (k < 6 && n < 300)
		begin
			@(posedge clk);
			n++;
			if (net_out[0].tvalid === 1'b1 && net_out_ready[0] === 1'b1)
			begin
				ev = exp_q.pop_front();
				`CHK("out data", ev, net_out[0].tdata)
				`CHK("out keep", 4'hf, net_out[0].tkeep)
				`CHK("out last", (k % 3 == 2), net_out[0].tlast)
				k++;
			end
			net_out_ready[0] <= 1'($urandom);
		end
		if (k < 6)
			failures++;
	endtask : recv

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rnd = $urandom(44149);
		rst = 1'b1;
		reg_req = '0;
		net_in = '0;
		net_out_ready = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_CONTROL, 32'h0000_000c, "control reset");
		rd(OFF_PKT_LEN, 32'h0000_0001, "pkt_len reset");
		rd(8'h3c, 32'h0, "unmapped");
		wr(OFF_CONTROL, 32'h0000_000e);
		rd(OFF_CONTROL, 32'h0000_000c, "read-only bits");
		$display("test register map done");
		for (int i = 0; i < 8; i++)
		begin
			vin[i] = $urandom;
			vio[i] = $urandom;
			wr(8'(OFF_IN_BASE + 4 * i), vin[i]);
			wr(8'(OFF_IO_BASE + 4 * i), vio[i]);
		end
		wr(OFF_CONTROL, 32'h0000_0001);
		#1 `CHK("launch set", 1'b1, launch_request)
		@(posedge clk);
		#1 `CHK("launch cleared", 1'b0, launch_request)
		for (int i = 0; i < 8; i++)
		begin
			`CHK("in scalar", vin[i], acc_in_scalar[i])
			`CHK("io scalar", vio[i], acc_io_scalar[i])
		end
		wr(OFF_IN_BASE, ~vin[0]);
		#1 `CHK("staged held", vin[0], acc_in_scalar[0])
		wait_done();
		rd(OFF_CONTROL, 32'h0000_000e, "finished set");
		rd(OFF_CONTROL, 32'h0000_000c, "finished cleared");
		for (int i = 0; i < 8; i++)
		begin
			rd(8'(OFF_OUT_BASE + 4 * i), ~vin[i], "out scalar");
			rd(8'(OFF_IO_BASE + 4 * i), io_expect(i, vio[i]), "io result");
		end
		$display("test launch and scalars done");
		wr(OFF_CONTROL, 32'h0000_0081);
		// Status flags trail the accelerator by a cycle, so idle and ready still show
		rd(OFF_CONTROL, 32'h0000_008c, "auto bit");
		wait_done();
		#1 `CHK("rerun", 1'b1, launch_request)
		wr(OFF_CONTROL, 32'h0000_0000);
		wait_done();
		repeat (3) @(posedge clk);
		#1 `CHK("no rerun", 1'b0, launch_request)
		rd(OFF_CONTROL, 32'h0000_000e, "after rerun");
		$display("test auto rerun done");
		wr(OFF_PKT_LEN, 32'h0000_0003);
		wr(OFF_PKT_LEN, 32'h0000_0000);
		rd(OFF_PKT_LEN, 32'h0000_0003, "pkt_len zero");
		fork
			send();
			recv();
		join
		`CHK("queue empty", 0, exp_q.size())
		$display("test streams done");
		print_verdict();
	end

endmodule : test_accelerator_control_interface
